// File: shared/ecc_pkg.sv
package ecc_pkg;

  // configuration register location on the internal register port
  localparam logic [11:0] ECC_CFG_OFFSET = 12'h521;
  localparam logic [31:0] ECC_CFG_RESET  = 32'h0000_0000;
  // only documented fields are stored, the rest read as zero
  localparam logic [31:0] ECC_CFG_MASK   = 32'h0000_5F07;

  // field positions
  localparam int ECC_BIT_ENABLE    = 0;
  localparam int ECC_BIT_FORCE     = 1;
  localparam int ECC_BIT_PULSE     = 2;
  localparam int ECC_RATE_LSB      = 8;
  localparam int ECC_RATE_MSB      = 10;
  localparam int ECC_BIT_CLK_SEL   = 11;
  localparam int ECC_BIT_OSC_SEL   = 12;
  localparam int ECC_BIT_OSC_HALT  = 14;

  // reference frequency codes, five supported
  localparam logic [2:0] ECC_RATE_1536K  = 3'h0;
  localparam logic [2:0] ECC_RATE_3072K  = 3'h1;
  localparam logic [2:0] ECC_RATE_6144K  = 3'h2;
  localparam logic [2:0] ECC_RATE_12288K = 3'h3;
  localparam logic [2:0] ECC_RATE_24576K = 3'h4;

  // derived clock domains: converter, mixer, processor, audio port, modulator
  localparam int ECC_NUM_DOMAINS = 5;

endpackage

// File: verilog/ecc_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module ecc_pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // raw pins and their settled levels
  input  wire logic [WIDTH-1:0] pinIn,
  output var  logic [WIDTH-1:0] pinLevel
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
  } ecc_sync_t;

  ecc_sync_t syncReg;
  ecc_sync_t syncNext;

  // stage1 feeds stage2 only; a level counts once stage2 and stage3 agree
  always_comb begin
    syncNext = syncReg;
    syncNext.stage1 = pinIn;
    syncNext.stage2 = syncReg.stage1;
    syncNext.stage3 = syncReg.stage2;
    for (int i = 0; i < WIDTH; i++) begin
      if (syncReg.stage2[i] == syncReg.stage3[i]) begin
        syncNext.level[i] = syncReg.stage3[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end

  assign pinLevel = syncReg.level;

endmodule
`default_nettype wire

// File: verilog/ecc_enable_clock_control.sv
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Every internal domain tick is derived from the one selected reference clock.
// - Bit 11 of the configuration register selects the master clock pin at 0 and the bit clock at 1.
// - Bits 10:8 declare the reference frequency, and only five codes are legal.
// - After reset shutdown is pin controlled, chosen by bit 1 being 0.
// - In pin level mode the device runs while the pin is high and stops while it is low.
// - With bit 2 set in pin mode each rising pin edge toggles enabled and disabled.
// - With bit 1 set the pin is ignored and bit 0 alone enables the device.
// - In software mode writing 0 to bit 0 disables and writing 1 enables.
// - Disabling never alters the configuration register contents.
// - The power management oscillator stops when bits 12 and 14 are both set.
module ecc_enable_clock_control
  import ecc_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // register port from the two-wire control decoder
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [11:0] regAddr,
  input  wire logic [31:0] regWrData,
  output var  logic [31:0] regRdData,
  // pins
  input  wire logic        shutdownPin,
  input  wire logic        mclkPin,
  input  wire logic        sclkPin,
  // status and derived clocks
  output var  logic        deviceEnabled,
  output var  logic        refClkSel,
  output var  logic        refClkOut,
  output var  logic [2:0]  clkRateCode,
  output var  logic        clkRateValid,
  output var  logic [ecc_pkg::ECC_NUM_DOMAINS-1:0] domainTick,
  output var  logic        oscRunning
);
  import ecc_pkg::*;

  typedef struct packed {
    logic [31:0]                cfg;
    logic [31:0]                rdData;
    logic                       enabled;
    logic                       stopPrev;
    logic                       refPrev;
    logic                       refOut;
    logic [ECC_NUM_DOMAINS-1:0] ticks;
    logic                       rateValid;
    logic                       oscRun;
  } ecc_state_t;

  ecc_state_t stateReg;
  ecc_state_t stateNext;

  logic [2:0] pinLevel;
  logic       stopLvl;
  logic       mclkLvl;
  logic       sclkLvl;
  logic       stopRise;
  logic       refLvl;
  logic       cfgHit;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, one bit each for shutdown and both clock pins
  ecc_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .pinIn    ({sclkPin, mclkPin, shutdownPin}),
    .pinLevel (pinLevel)
  );

  assign stopLvl = pinLevel[0];
  assign mclkLvl = pinLevel[1];
  assign sclkLvl = pinLevel[2];
  assign cfgHit  = (regAddr == ECC_CFG_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    stateNext = stateReg;
    stopRise  = stopLvl & ~stateReg.stopPrev; // settled level only, one toggle per edge
    // register write; disabled state keeps the contents as they are
    if (regWrEn && cfgHit) begin
      stateNext.cfg = regWrData & ECC_CFG_MASK;
    end
    // read answer one cycle later, unmapped addresses read zero
    stateNext.rdData = (regRdEn && cfgHit) ? stateReg.cfg : 32'h0000_0000;
    stateNext.stopPrev = stopLvl;
    // shutdown control; software mode wins over the pin
    if (stateReg.cfg[ECC_BIT_FORCE]) begin
      stateNext.enabled = stateReg.cfg[ECC_BIT_ENABLE];
    end else if (stateReg.cfg[ECC_BIT_PULSE]) begin
      if (stopRise) begin
        stateNext.enabled = ~stateReg.enabled;
      end
    end else begin
      stateNext.enabled = stopLvl;
    end
    // reference selection; the pin chosen must be running
    refLvl = stateReg.cfg[ECC_BIT_CLK_SEL] ? sclkLvl : mclkLvl;
    stateNext.refPrev = refLvl;
    stateNext.refOut  = refLvl;
    // all domains tick on the same reference edge, and only while enabled
    stateNext.ticks = {ECC_NUM_DOMAINS{refLvl & ~stateReg.refPrev & stateReg.enabled}};
    // the rate code is only flagged, not corrected, so software sees its mistake
    stateNext.rateValid = (stateReg.cfg[ECC_RATE_MSB:ECC_RATE_LSB] <= ECC_RATE_24576K);
    stateNext.oscRun = ~(stateReg.cfg[ECC_BIT_OSC_SEL] & stateReg.cfg[ECC_BIT_OSC_HALT]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateReg        <= '0;
      stateReg.cfg    <= ECC_CFG_RESET;
      stateReg.oscRun <= 1'b1;
    end else begin
      stateReg <= stateNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops
  assign regRdData     = stateReg.rdData;
  assign deviceEnabled = stateReg.enabled;
  assign refClkSel     = stateReg.cfg[ECC_BIT_CLK_SEL];
  assign refClkOut     = stateReg.refOut;
  assign clkRateCode   = stateReg.cfg[ECC_RATE_MSB:ECC_RATE_LSB];
  assign clkRateValid  = stateReg.rateValid;
  assign domainTick    = stateReg.ticks;
  assign oscRunning    = stateReg.oscRun;

endmodule
`default_nettype wire

// File: tb/ecc_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module ecc_assertions
  import ecc_pkg::*;
(
  // watched ports of the block
  input wire logic        sys_clk, rst_b, regWrEn, regRdEn, shutdownPin,
  input wire logic        deviceEnabled, refClkSel, oscRunning,
  input wire logic [2:0]  clkRateCode,
  input wire logic [4:0]  domainTick,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData, regRdData
);
  logic [31:0] cfg;
  // mirror of the word, so checks know the shutdown mode
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) cfg <= ECC_CFG_RESET;
    else if (regWrEn && regAddr == ECC_CFG_OFFSET) cfg <= regWrData & ECC_CFG_MASK;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // a write, then two quiet cycles so every output has landed
  sequence s_wq; regWrEn && regAddr == ECC_CFG_OFFSET ##1 !regWrEn [*2]; endsequence
  a_sel_bit: assert property (s_wq |=> refClkSel == $past(regWrData[11], 3))
    else $error("bad select");
  a_rate_code: assert property (s_wq |=> clkRateCode == $past(regWrData[10:8], 3))
    else $error("bad rate");
  a_osc_stop: assert property (s_wq |=> oscRunning != $past(regWrData[14] & regWrData[12], 3))
    else $error("bad oscillator");
  a_read_back: assert property (regRdEn && regAddr == ECC_CFG_OFFSET |=> regRdData == $past(cfg))
    else $error("bad readback");
  a_level_mode: assert property ((cfg[2:1] == 2'h0 && $stable(shutdownPin)) [*8]
    |-> deviceEnabled == shutdownPin) else $error("bad level mode");
  a_soft_mode: assert property ($past(cfg[1]) |-> deviceEnabled == $past(cfg[0]))
    else $error("bad software mode");
  a_pulse_flip: assert property (cfg[2:1] == 2'h2 && $rose(shutdownPin) ##1
    (cfg[2:1] == 2'h2 && shutdownPin) [*6] |-> deviceEnabled != $past(deviceEnabled, 6))
    else $error("bad toggle");
  a_tick_gate: assert property (domainTick != 5'h00 |-> domainTick == 5'h1F &&
    (deviceEnabled || $past(deviceEnabled)) ##1 domainTick == 5'h00) else $error("bad tick");
endmodule
bind ecc_enable_clock_control ecc_assertions u_chk (.*);
`default_nettype wire

// File: tb/ecc_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module ecc_far_side (
  // level wanted by the bench, pins into the device
  input  wire logic pinReq,
  output var  logic shutdownPin,
  output var  logic mclkPin = 1'b0,
  output var  logic sclkPin = 1'b0
);
  // references run free; the bit clock is the slower, cheaper pick
  always #40 mclkPin = !mclkPin;
  always #160 sclkPin = !sclkPin;
  // steady level between requests, never an edge train
  always_comb shutdownPin = pinReq;
endmodule
`default_nettype wire

// File: tb/ecc_enable_clock_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ecc_enable_clock_control_tb_top;
  import ecc_pkg::*;
  localparam logic [11:0] CFG = ECC_CFG_OFFSET;
  // bench inputs and design outputs
  logic        sys_clk = 1'b0, rst_b = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, pinReq = 1'b1;
  logic        shutdownPin, mclkPin, sclkPin, deviceEnabled, refClkSel, refClkOut;
  logic        clkRateValid, oscRunning;
  logic [2:0]  clkRateCode;
  logic [4:0]  domainTick;
  logic [11:0] regAddr = CFG;
  logic [31:0] regWrData = 32'h0000_0000, regRdData;
  int          err_total = 0, total_checks = 0;
  always #5 sys_clk = !sys_clk;
  ecc_far_side far (.*);
  ecc_enable_clock_control dut (.*);
  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) err_total++;
    if (s !== e) $display("wrong value at %0t: %h, wanted %h", $time, s, e);
  endtask
  // one access; read data stands a single cycle, so look at once
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {regWrEn, regRdEn, regAddr, regWrData} <= {w, !w, a, d};
    @(posedge sys_clk);
    {regWrEn, regRdEn} <= 2'b00;
    #1 if (!w) chk(regRdData, d);
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // move the pin, let the synchroniser settle, then look
  task automatic pin(input logic v, input logic e);
    @(posedge sys_clk);
    pinReq <= v;
    repeat (8) @(posedge sys_clk);
    #1 chk(deviceEnabled, e);
  endtask
  // count ticks and reference rises over 200 cycles; the reference runs even while disabled
  task automatic ticks(input int lo, input int hi, input int rlo, input int rhi);
    int n = 0;
    int r = 0;
    logic p = refClkOut;
    repeat (200) @(posedge sys_clk) begin
      #1;
      n += domainTick[0];
      r += int'(refClkOut & !p);
      p = refClkOut;
    end
    chk(n >= lo && n <= hi, 1'b1);
    chk(r >= rlo && r <= rhi, 1'b1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    acc(1'b0, CFG, 32'h0000_0000);
    pin(1'b1, 1'b1);
    pin(1'b0, 1'b0);
    acc(1'b1, CFG, 32'h0000_0004);
    pin(1'b1, 1'b1);
    pin(1'b0, 1'b1);
    pin(1'b1, 1'b0);
    acc(1'b1, CFG, 32'h0000_0003);
    pin(1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, CFG, i << 8 | i % 2 << 11 | 3);
      chk({refClkSel, clkRateValid, clkRateCode}, {i % 2 == 1, i < 5, i[2:0]});
    end
    ticks(6, 7, 6, 7);
    acc(1'b1, CFG, 32'h0000_5002);
    acc(1'b1, 12'h0520, 32'hFFFF_FFFF);
    acc(1'b0, 12'h0520, 32'h0000_0000);
    acc(1'b0, CFG, 32'h0000_5002);
    chk({oscRunning, deviceEnabled}, 2'b00);
    ticks(0, 0, 24, 26);
    report_and_stop;
  end
endmodule
`default_nettype wire
